//--- sim/req_model.sv
// Behavioural memory requesters facing the arbiter's grant vector.
// Assumes the bench pulses want bits; service lasts LEN granted cycles.
`timescale 1ns/1ps
module req_model #(
    parameter int LEN = 16
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] want,
    input  wire logic [7:0] gnt,
    output logic [7:0]      req_q,
    output logic            svc_done
);
    // ---------------------------------------------------------------
    // Request and service tracking
    // ---------------------------------------------------------------
    logic [7:0] cnt_q;

    // Requests held until the granted service ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= 8'h00;
        end else begin
            req_q <= (req_q | want) & ~(gnt & {8{svc_done}});
        end
    end

    // Cycles since grant; a preempted agent starts over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else if (gnt == 8'h00 || svc_done) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign svc_done = (gnt != 8'h00) && (cnt_q == 8'(LEN - 1));
endmodule : req_model

//--- sim/testbench.sv
// Self-checking bench for the memory arbiter: APB and request sequences.
// Assumes one wait state on APB and the requester model as far side.
`timescale 1ns/1ps
module testbench;
    import arb_pkg::*;

    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, want, req, gnt, disp_level, vid_level;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] scan_x;
    logic        cas_boundary, seq_end, svc_done, err;
    int          mismatches, compares, cycles;

    mem_arbiter i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_req(req[0]), .pci_req(req[1]), .isa_req(req[2]),
        .gfx_req(req[3]), .disp_req(req[4]), .vout_req(req[5]),
        .vin_req(req[6]), .ref_req(req[7]), .disp_level(disp_level),
        .vid_level(vid_level), .scan_x(scan_x),
        .cas_boundary(cas_boundary), .seq_end(seq_end),
        .svc_done(svc_done), .gnt(gnt)
    );

    req_model #(.LEN(16)) i_req (
        .pclk(pclk), .presetn(presetn), .want(want), .gnt(gnt),
        .req_q(req), .svc_done(svc_done)
    );

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic ask(input logic [7:0] m);
        @(posedge pclk); want <= m;
        @(posedge pclk); want <= 8'h00;
    endtask : ask

    // Waits for the current grant to end and the next to begin
    task automatic wait_gnt(input logic [7:0] exp);
        int n;
        n = 0;
        while (gnt !== 8'h00 && n < 60) begin @(negedge pclk); n++; end
        while (gnt === 8'h00 && n < 120) begin @(negedge pclk); n++; end
        check("gnt", {24'h0, gnt}, {24'h0, exp});
        @(posedge pclk);
    endtask : wait_gnt

    // Graphics holds memory while two others queue behind it
    task automatic queued(input logic [7:0] m, e1, e2);
        ask(8'h08);
        wait_gnt(8'h08);
        ask(m);
        wait_gnt(e1);
        wait_gnt(e2);
    endtask : queued

    task automatic strobe(input logic cas);
        @(posedge pclk);
        if (cas) cas_boundary <= 1'b1; else seq_end <= 1'b1;
        @(posedge pclk);
        cas_boundary <= 1'b0; seq_end <= 1'b0;
    endtask : strobe

    // ---------------------------------------------------------------
    // Clock, reset, timeout
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, cas_boundary, seq_end} = 6'h00;
        paddr = 8'h00; pwdata = 32'h0000_0000; want = 8'h00;
        disp_level = 8'hFF; vid_level = 8'hFF; scan_x = 12'h000;
        mismatches = 0; compares = 0; cycles = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped place, read-only status
        apb(1'b0, OFS_CTRL, 32'h0); check("ctrl", rd, RST_CTRL);
        apb(1'b0, OFS_NEAR, 32'h0); check("near", rd, RST_NEAR);
        apb(1'b0, OFS_LWM_A, 32'h0); check("lwma", rd, RST_LWM_A);
        apb(1'b0, OFS_BURST, 32'h0); check("burst", rd, RST_BURST);
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF); check("slverr", 32'(err), 1);
        apb(1'b1, OFS_STATUS, 32'h0000_0F00);
        check("st_err", 32'(err), 0);
        // Far mode order among direct agents
        ask(8'hF8);
        wait_gnt(8'h08);
        wait_gnt(8'h40);
        wait_gnt(8'h20);
        wait_gnt(8'h10);
        wait_gnt(8'h80);
        // Urgent display beats the system master
        disp_level <= 8'h08;
        queued(8'h11, 8'h10, 8'h01);
        disp_level <= 8'hFF;
        // Low video level is not urgent far from the window
        vid_level <= 8'h10;
        queued(8'h21, 8'h01, 8'h20);
        // System master cuts graphics at a column boundary
        ask(8'h08);
        wait_gnt(8'h08);
        ask(8'h01);
        strobe(1'b1);
        wait_gnt(8'h01);
        wait_gnt(8'h08);
        // Urgent display cuts the still running graphics at sequence end
        check("gfx_held", {24'h0, gnt}, 32'h0000_0008);
        disp_level <= 8'h08;
        ask(8'h10);
        strobe(1'b0);
        wait_gnt(8'h10);
        wait_gnt(8'h08);
        disp_level <= 8'hFF;
        // Near the window: alternate marks, urgent video wins
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_WIN, 32'h0080_0100);
        scan_x <= 12'h0E0;
        apb(1'b0, OFS_STATUS, 32'h0);
        check("st_near", 32'(rd[11:8]), 32'h0000_0001);
        // Let the graphics service end before graphics asks again
        while (gnt !== 8'h00) begin
            @(negedge pclk);
        end
        queued(8'h21, 8'h20, 8'h01);
        // Inside the window the mark falls with the remaining width
        scan_x <= 12'h140;
        vid_level <= 8'h14;
        ask(8'h20);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("st_in", 32'(rd[11:8]), 32'h2);
        vid_level <= 8'h0C;
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("st_urg", 32'(rd[11:8]), 32'hA);
        report_and_stop();
    end
endmodule : testbench

//--- verilog/arb_pkg.sv
// Constants shared by the memory arbiter and its testbench.
// Assumes a 32-bit APB slave with byte addresses on paddr[7:0].
package arb_pkg;

    // -----------------------------------------------------------------
    // Register offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_WIN     = 8'h04;
    localparam logic [7:0] OFS_NEAR    = 8'h08;
    localparam logic [7:0] OFS_LWM_N   = 8'h0C;
    localparam logic [7:0] OFS_LWM_A   = 8'h10;
    localparam logic [7:0] OFS_BURST   = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int F_WIN_EN   = 0;
    localparam int F_LO       = 0;   // Low field of a pair
    localparam int F_HI8      = 8;   // Upper byte field
    localparam int F_HI12     = 16;  // Upper 12-bit field
    localparam int F_ST_MODE  = 8;
    localparam int F_ST_DURG  = 10;
    localparam int F_ST_VURG  = 11;
    localparam int F_ST_BUSY  = 12;

    // -----------------------------------------------------------------
    // Values after reset
    // -----------------------------------------------------------------
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RST_WIN   = 32'h0000_0000;
    localparam logic [31:0] RST_NEAR  = 32'h0000_0040;
    localparam logic [31:0] RST_LWM_N = 32'h0000_0010;
    localparam logic [31:0] RST_LWM_A = 32'h0000_2020;
    localparam logic [31:0] RST_BURST = 32'h0000_0808;

    // -----------------------------------------------------------------
    // Agent positions in the grant vector
    // -----------------------------------------------------------------
    localparam int AG_CPU  = 0;
    localparam int AG_PCI  = 1;
    localparam int AG_ISA  = 2;
    localparam int AG_GFX  = 3;
    localparam int AG_DISP = 4;
    localparam int AG_VOUT = 5;
    localparam int AG_VIN  = 6;
    localparam int AG_REF  = 7;

    typedef enum logic [1:0] {
        MODE_FAR  = 2'b00,
        MODE_NEAR = 2'b01,
        MODE_IN   = 2'b10
    } mode_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } arb_st_t;

endpackage : arb_pkg

//--- verilog/mem_arbiter.sv
// Dynamic shared-memory arbiter with APB register access.
// Assumes requesters, FIFO levels and scan position are on pclk.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module mem_arbiter
    import arb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_req,
    input  wire logic        pci_req,
    input  wire logic        isa_req,
    input  wire logic        gfx_req,
    input  wire logic        disp_req,
    input  wire logic        vout_req,
    input  wire logic        vin_req,
    input  wire logic        ref_req,
    input  wire logic [7:0]  disp_level,
    input  wire logic [7:0]  vid_level,
    input  wire logic [11:0] scan_x,
    input  wire logic        cas_boundary,
    input  wire logic        seq_end,
    input  wire logic        svc_done,
    output logic [7:0]       gnt
);

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic        win_en_q;
    logic [11:0] win_x_q;
    logic [11:0] win_w_q;
    logic [11:0] near_q;
    logic [7:0]  dlwm_n_q;
    logic [7:0]  dlwm_a_q;
    logic [7:0]  vlwm_a_q;
    logic [7:0]  dburst_q;
    logic [7:0]  vburst_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [7:0]  gnt_q;
    logic [7:0]  gnt_d;
    logic [7:0]  cnt_q;
    arb_st_t     st_q;
    mode_t       mode;
    logic        alt;
    logic [12:0] win_end;
    logic [12:0] near_pos;
    logic        in_win;
    logic [11:0] rem;
    logic [11:0] span;
    logic [7:0]  dmark;
    logic        durg_raw;
    logic        vurg_raw;
    logic        disp_urg;
    logic        vid_urg;
    logic [2:0]  sys_sel;
    logic [2:0]  sys_live;
    logic        sys_any;
    logic        sys_hold;
    logic        win_v;
    logic        preempt;
    logic        release_now;
    logic        access;
    logic        addr_hit;
    logic [31:0] rd_mux;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign gnt     = gnt_q;

    // -----------------------------------------------------------------
    // Scan position against the video window
    // -----------------------------------------------------------------
    // Window modes decide which marks rule urgency
    assign win_end  = {1'b0, win_x_q} + {1'b0, win_w_q};
    assign near_pos = {1'b0, scan_x} + {1'b0, near_q};
    assign in_win   = win_en_q && (scan_x >= win_x_q)
                      && ({1'b0, scan_x} < win_end);
    always_comb begin
        if (in_win) begin
            mode = MODE_IN;
        end else if (win_en_q && scan_x < win_x_q
                     && near_pos >= {1'b0, win_x_q}) begin
            mode = MODE_NEAR;
        end else begin
            mode = MODE_FAR;
        end
    end
    assign alt = (mode != MODE_FAR);

    // Remaining window share scales the marks down to 1/span at the last window pixel
    assign rem   = in_win ? 12'(win_end - {1'b0, scan_x}) : 12'h001;
    assign span  = in_win ? win_w_q : 12'h001;
    assign dmark = alt ? dlwm_a_q : dlwm_n_q;

    // -----------------------------------------------------------------
    // Helpers: urgency compares and system master choice
    // -----------------------------------------------------------------
    urgency_cmp #(.LW(8), .XW(12)) u_disp_urg (
        .clk      (pclk),
        .rst_n    (presetn),
        .level    (disp_level),
        .mark     (dmark),
        .rem      (rem),
        .span     (span),
        .urgent_q (durg_raw)
    );

    urgency_cmp #(.LW(8), .XW(12)) u_vid_urg (
        .clk      (pclk),
        .rst_n    (presetn),
        .level    (vid_level),
        .mark     (vlwm_a_q),
        .rem      (rem),
        .span     (span),
        .urgent_q (vurg_raw)
    );

    sys_master_arb u_sys_arb (
        .clk   (pclk),
        .rst_n (presetn),
        .req   ({isa_req, pci_req, cpu_req}),
        .hold  (sys_hold),
        .sel_q (sys_sel)
    );

    assign disp_urg = durg_raw && disp_req;
    assign vid_urg  = vurg_raw && vout_req && alt;
    // Held choice counts only while its master still asks; a served
    // master's stale choice would otherwise be granted again
    assign sys_live = sys_sel & {isa_req, pci_req, cpu_req};
    assign sys_any  = |sys_live;

    // -----------------------------------------------------------------
    // Winner selection
    // -----------------------------------------------------------------
    // Fixed order; window modes only add urgent video near the top
    always_comb begin
        gnt_d = 8'h00;
        win_v = 1'b1;
        if (disp_urg) begin
            gnt_d[AG_DISP] = 1'b1;
        end else if (vid_urg) begin
            gnt_d[AG_VOUT] = 1'b1;
        end else if (sys_any) begin
            gnt_d[AG_ISA:AG_CPU] = sys_live;
        end else if (gfx_req) begin
            gnt_d[AG_GFX] = 1'b1;
        end else if (vin_req) begin
            gnt_d[AG_VIN] = 1'b1;
        end else if (vout_req) begin
            gnt_d[AG_VOUT] = 1'b1;
        end else if (disp_req) begin
            gnt_d[AG_DISP] = 1'b1;
        end else if (ref_req) begin
            gnt_d[AG_REF] = 1'b1;
        end else begin
            win_v = 1'b0;
        end
    end

    assign sys_hold = (|gnt_q[AG_ISA:AG_CPU])
                      || (st_q == ST_IDLE && |gnt_d[AG_ISA:AG_CPU]);

    // Service cut short by a stronger requester, or graphics by any display request at sequence end
    always_comb begin
        preempt = 1'b0;
        if (gnt_q[AG_GFX]) begin
            preempt = (sys_any && cas_boundary)
                      || (disp_req && seq_end);
        end else if (gnt_q[AG_DISP]) begin
            preempt = vid_urg && (cnt_q >= dburst_q);
        end else if (gnt_q[AG_VOUT]) begin
            preempt = alt && disp_urg && (cnt_q >= vburst_q);
        end
    end
    assign release_now = svc_done || preempt;

    // -----------------------------------------------------------------
    // Grant state
    // -----------------------------------------------------------------
    // One grant, kept until done or cut; one idle cycle between
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= ST_IDLE;
            gnt_q <= 8'h00;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (win_v) begin
                        gnt_q <= gnt_d;
                        st_q  <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (release_now) begin
                        gnt_q <= 8'h00;
                        st_q  <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Service length, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else if (st_q == ST_IDLE) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hFF) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // -----------------------------------------------------------------
    // APB slave: one wait state, error on unmapped offsets
    // -----------------------------------------------------------------
    assign access   = psel && penable && pready_q;
    assign addr_hit = (paddr <= OFS_STATUS) && (paddr[1:0] == 2'b00);

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL:   rd_mux[F_WIN_EN] = win_en_q;
            OFS_WIN:    rd_mux = {4'h0, win_w_q, 4'h0, win_x_q};
            OFS_NEAR:   rd_mux[11:0] = near_q;
            OFS_LWM_N:  rd_mux[7:0] = dlwm_n_q;
            OFS_LWM_A:  rd_mux[15:0] = {vlwm_a_q, dlwm_a_q};
            OFS_BURST:  rd_mux[15:0] = {vburst_q, dburst_q};
            OFS_STATUS: begin
                rd_mux[7:0] = gnt_q;
                rd_mux[F_ST_MODE+1:F_ST_MODE] = mode;
                rd_mux[F_ST_DURG] = disp_urg;
                rd_mux[F_ST_VURG] = vid_urg;
                rd_mux[F_ST_BUSY] = st_q;
            end
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // Answer in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_hit;
            if (psel && penable && !pready_q) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Configuration writes land at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_en_q <= RST_CTRL[F_WIN_EN];
            win_x_q  <= RST_WIN[F_LO+:12];
            win_w_q  <= RST_WIN[F_HI12+:12];
            near_q   <= RST_NEAR[F_LO+:12];
            dlwm_n_q <= RST_LWM_N[F_LO+:8];
            dlwm_a_q <= RST_LWM_A[F_LO+:8];
            vlwm_a_q <= RST_LWM_A[F_HI8+:8];
            dburst_q <= RST_BURST[F_LO+:8];
            vburst_q <= RST_BURST[F_HI8+:8];
        end else if (access && pwrite) begin
            unique case (paddr)
                OFS_CTRL:  win_en_q <= pwdata[F_WIN_EN];
                OFS_WIN: begin
                    win_x_q <= pwdata[F_LO+:12];
                    win_w_q <= pwdata[F_HI12+:12];
                end
                OFS_NEAR:  near_q <= pwdata[F_LO+:12];
                OFS_LWM_N: dlwm_n_q <= pwdata[F_LO+:8];
                OFS_LWM_A: begin
                    dlwm_a_q <= pwdata[F_LO+:8];
                    vlwm_a_q <= pwdata[F_HI8+:8];
                end
                OFS_BURST: begin
                    dburst_q <= pwdata[F_LO+:8];
                    vburst_q <= pwdata[F_HI8+:8];
                end
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_grant_single: assert property ($onehot0(gnt_q))
        else $error("more than one grant");
    chk_refresh_last: assert property ($rose(gnt_q[AG_REF]) |->
        $past(!(sys_any || gfx_req || disp_req || vout_req || vin_req)))
        else $error("refresh granted over a requester");
    chk_urgent_disp: assert property (st_q == ST_IDLE && disp_urg
        |=> gnt_q[AG_DISP] && st_q == ST_BUSY)
        else $error("urgent display not granted");
    chk_gfx_loses: assert property (st_q == ST_IDLE && sys_any
        && gfx_req |=> !gnt_q[AG_GFX])
        else $error("graphics beat system master");
    chk_gfx_cas_cut: assert property (gnt_q[AG_GFX] && sys_any
        && cas_boundary |=> gnt_q == 8'h00 ##1 |gnt_q)
        else $error("graphics not cut at column boundary");
    chk_gfx_seq_cut: assert property (gnt_q[AG_GFX] && disp_req
        && seq_end |=> gnt_q == 8'h00)
        else $error("graphics not cut at sequence end");
    chk_vout_low: assert property (st_q == ST_IDLE && !alt
        && (sys_any || gfx_req || vin_req) |=> !gnt_q[AG_VOUT])
        else $error("video output beat higher agent");
    chk_disp_burst: assert property (gnt_q[AG_DISP] && !svc_done
        && cnt_q < dburst_q |=> gnt_q[AG_DISP])
        else $error("display burst interrupted early");
    chk_window_others: assert property (st_q == ST_IDLE && alt
        && (disp_urg || vid_urg) |=> (gnt_q[AG_DISP] || gnt_q[AG_VOUT]))
        else $error("other agent served while fifo urgent");
    chk_apb_answer: assert property (psel && penable && !pready_q
        |=> pready_q ##1 !pready_q)
        else $error("apb answer not one wait state");

    cov_sys_grant:  cover property (|gnt_q[AG_ISA:AG_CPU]);
    cov_gfx_cut:    cover property (gnt_q[AG_GFX] ##1 gnt_q == 8'h00
                                    ##1 |gnt_q[AG_ISA:AG_CPU]);
    cov_vid_urgent: cover property (st_q == ST_IDLE && vid_urg);
    cov_refresh:    cover property ($rose(gnt_q[AG_REF]));

endmodule : mem_arbiter

//--- verilog/sys_master_arb.sv
// Round-robin choice of one system master among CPU, PCI and ISA.
// Assumes requests are held until granted; hold freezes the choice.
`timescale 1ns/1ps
module sys_master_arb (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] req,
    input  wire logic       hold,
    output logic [2:0]      sel_q
);

    logic [1:0] last_q;
    logic [2:0] pick;
    int         k;

    // Nearest requester after the last one served wins
    always_comb begin
        pick = '0;
        k = 0;
        for (int i = 3; i >= 1; i--) begin
            k = (int'(last_q) + i) % 3;
            if (req[k]) begin
                pick = '0;
                pick[k] = 1'b1;
            end
        end
    end

    // Choice tracks requests until the memory side holds it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q  <= 3'h0;
            last_q <= 2'h0;
        end else if (!hold) begin
            sel_q <= pick;
        end else begin
            last_q <= sel_q[2] ? 2'd2 : (sel_q[1] ? 2'd1 : 2'd0);
        end
    end

endmodule : sys_master_arb

//--- verilog/urgency_cmp.sv
// Urgency test of one FIFO against a linearly falling low water mark.
// Assumes level, mark and scan figures come from the pclk domain.
`timescale 1ns/1ps
module urgency_cmp #(
    parameter int LW = 8,
    parameter int XW = 12
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [LW-1:0] level,
    input  wire logic [LW-1:0] mark,
    input  wire logic [XW-1:0] rem,
    input  wire logic [XW-1:0] span,
    output logic               urgent_q
);

    logic [LW+XW-1:0] lhs;
    logic [LW+XW-1:0] rhs;

    // level < mark * rem / span, without a divider
    assign lhs = level * span;
    assign rhs = mark * rem;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            urgent_q <= 1'b0;
        end else begin
            urgent_q <= lhs < rhs;
        end
    end

endmodule : urgency_cmp
